// ==== logic/lsu_agen.sv ====
// effective address and cache-policy decision
`timescale 1ns/100ps
`include "lsu_consts.svh"
module lsu_agen #(
    parameter bit HAS_MMU = 1'b0,
    parameter bit HAS_BYPASS31 = 1'b1
) (
    // operands
    input wire logic [31:0] base,
    input wire logic [15:0] imm,
    input wire logic io_op,
    input wire logic mmu_cacheable,
    // result
    output logic [31:0] eff_addr,
    output logic [31:0] bus_addr,
    output logic cacheable
);
    // base plus sign-extended immediate
    always_comb
    begin
        eff_addr = base + {{16{imm[15]}}, imm};
        bus_addr = eff_addr;
        if (HAS_MMU)
            cacheable = mmu_cacheable & ~io_op;
        else if (HAS_BYPASS31)
            cacheable = ~eff_addr[`LSU_BYPASS_BIT] & ~io_op;
        else
            cacheable = ~io_op;
        if (!HAS_MMU)
            bus_addr = {1'b0, eff_addr[`LSU_NOMMU_ADDR_W-1:0]};
    end
endmodule // lsu_agen

// ==== logic/lsu_consts.svh ====
// constants for the load/store unit: field positions, sizes and cache geometry
`ifndef LSU_CONSTS_SVH
`define LSU_CONSTS_SVH
`define LSU_ADDR_W 32
`define LSU_DATA_W 32
`define LSU_BYPASS_BIT 31
`define LSU_NOMMU_ADDR_W 31
`define LSU_PAGE_BITS 12
`define LSU_LINE_BITS 4
`define LSU_INDEX_BITS 8
`define LSU_LINES 256
`define LSU_TAG_W 20
`define LSU_IMM_W 16
`endif

// ==== logic/lsu_core.sv ====
// load/store unit: address, cache, bus sequencing
`timescale 1ns/100ps
`include "lsu_consts.svh"
// Functional notes
// - addresses are 32 bits wide
// - no MMU limits addresses to 31 bits
// - one shared address space, unmapped undefined
// - 32-bit bus, byte/half/word transfers
// - little-endian byte ordering
// - address is base plus signed immediate
// - without MMU bit 31 bypasses cache
// - with MMU translation decides cacheability
// - normal accesses may be cached or buffered
// - io accesses uncached, ordered, never suppressed
// - signed loads sign-extend, unsigned zero-extend
// - sub-word stores write only low bits
// - io sub-word forms uncached, same extension
// - cacheless build makes cache ops no-ops
// - virtual index, physical tag compare
// - tag holds full physical frame number
// - coherence only by software cache instructions
// - only loads and stores touch memory
module lsu_core #(
    parameter bit HAS_MMU = 1'b0,
    parameter bit HAS_BYPASS31 = 1'b1,
    parameter bit HAS_DCACHE = 1'b1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // request from the pipeline
    input wire logic req_valid,
    output logic req_ready,
    input wire lsu_pkg::lsu_op_e req_op,
    input wire lsu_pkg::lsu_size_e req_size,
    input wire logic req_signed,
    input wire logic req_io,
    input wire logic [31:0] req_base,
    input wire logic [15:0] req_imm,
    input wire logic [31:0] req_wdata,
    // translation result, same cycle as request
    input wire logic [19:0] xlat_frame,
    input wire logic xlat_cacheable,
    // load result
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // data bus master
    output logic bus_read,
    output logic bus_write,
    output logic [31:0] bus_addr,
    output logic [3:0] bus_byteenable,
    output logic [31:0] bus_wdata,
    input wire logic [31:0] bus_rdata,
    input wire logic bus_waitrequest
);
    typedef enum logic [1:0] {ST_IDLE, ST_BUS, ST_DONE} lsu_state_e;

    // whole state of the unit except the cache arrays
    typedef struct packed {
        lsu_state_e state;
        logic is_load;
        logic fill; // read also fills the cache line
        lsu_pkg::lsu_size_e size;
        logic sgn;
        logic [1:0] alo;
        logic [7:0] idx;
        logic [19:0] frame;
        logic [31:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic rvalid;
    } lsu_state_s;

    lsu_state_s s_q;
    lsu_state_s s_d;
    logic [31:0] eff_addr; // virtual effective address
    logic [31:0] phys_addr; // address driven to the bus
    logic cacheable; // policy for this access
    logic [31:0] st_lanes; // store data in lanes
    logic [3:0] st_be; // store byte enables
    logic [31:0] ld_ext; // extended load value
    logic [31:0] ld_src; // word to extend
    logic [1:0] ext_alo; // lane select for extension
    lsu_pkg::lsu_size_e ext_size;
    logic ext_sgn;
    logic [31:0] line_data [`LSU_LINES]; // one word per line for data
    logic [19:0] line_tag [`LSU_LINES]; // full frame number per line
    logic [`LSU_LINES-1:0] line_ok; // valid bits
    logic [1:0] line_wsel [`LSU_LINES]; // which word of its line each entry holds
    logic [7:0] idx; // line index from virtual bits
    logic [19:0] frame; // physical frame for tag compare
    logic hit; // cached load hit
    logic hit_word; // the cached word is the one addressed
    logic do_wr_cache; // store updates cache copy
    logic do_fill; // fill line from bus read
    logic do_inv; // invalidate one line
    logic do_inv_all; // initialize whole cache

    // address and cache policy
    lsu_agen #(
        .HAS_MMU(HAS_MMU),
        .HAS_BYPASS31(HAS_BYPASS31)
    ) u_agen (
        .base(req_base),
        .imm(req_imm),
        .io_op(req_io),
        .mmu_cacheable(xlat_cacheable),
        .eff_addr(eff_addr),
        .bus_addr(phys_addr),
        .cacheable(cacheable)
    );

    // index inside page offset keeps virtual index equal to physical
    assign idx = eff_addr[`LSU_PAGE_BITS-1:`LSU_LINE_BITS];
    // without an MMU the frame is the upper address itself
    assign frame = HAS_MMU ? xlat_frame : phys_addr[31:`LSU_PAGE_BITS];
    // four words share an index, so the held word offset must match too
    assign hit_word = (line_wsel[idx] == eff_addr[3:2]);
    assign hit = HAS_DCACHE && cacheable && line_ok[idx] && line_tag[idx] == frame
        && hit_word;

    // extension uses request on a hit, latched fields on bus return
    assign ext_alo = (s_q.state == ST_IDLE) ? eff_addr[1:0] : s_q.alo;
    assign ext_size = (s_q.state == ST_IDLE) ? req_size : s_q.size;
    assign ext_sgn = (s_q.state == ST_IDLE) ? req_signed : s_q.sgn;
    assign ld_src = (s_q.state == ST_IDLE) ? line_data[idx] : bus_rdata;

    lsu_lane u_lane (
        .addr_lo(ext_alo),
        .size(ext_size),
        .is_signed(ext_sgn),
        .st_src(req_wdata),
        .st_lanes(st_lanes),
        .st_be(st_be),
        .ld_bus(ld_src),
        .ld_result(ld_ext)
    );

    // next-state logic
    always_comb
    begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        do_wr_cache = 1'b0;
        do_fill = 1'b0;
        do_inv = 1'b0;
        do_inv_all = 1'b0;
        case (s_q.state)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    s_d.is_load = (req_op == lsu_pkg::LSU_OP_LOAD);
                    s_d.size = req_size;
                    s_d.sgn = req_signed;
                    s_d.alo = eff_addr[1:0];
                    s_d.idx = idx;
                    s_d.frame = frame;
                    s_d.addr = {phys_addr[31:2], 2'h0};
                    s_d.fill = cacheable && req_size == lsu_pkg::LSU_WORD;
                    s_d.be = st_be;
                    s_d.wdata = st_lanes;
                    if (req_op == lsu_pkg::LSU_OP_LOAD && hit)
                    begin
                        // cached load served with no bus cycle
                        s_d.rdata = ld_ext;
                        s_d.rvalid = 1'b1;
                    end
                    else if (req_op == lsu_pkg::LSU_OP_LOAD)
                    begin
                        s_d.be = 4'hf; // reads fetch the whole word
                        s_d.state = ST_BUS;
                    end
                    else if (req_op == lsu_pkg::LSU_OP_STORE)
                    begin
                        // write-through keeps memory current; io never updates cache
                        do_wr_cache = HAS_DCACHE && cacheable && hit;
                        s_d.state = ST_BUS;
                    end
                    else if (req_op == lsu_pkg::LSU_OP_INIT)
                        do_inv_all = HAS_DCACHE;
                    else if (req_op == lsu_pkg::LSU_OP_FLUSH)
                        do_inv = HAS_DCACHE;
                    // any other op makes no memory access
                end
            end
            ST_BUS:
            begin
                // hold the cycle until the slave lets go
                if (!bus_waitrequest)
                begin
                    if (s_q.is_load)
                    begin
                        s_d.rdata = ld_ext;
                        s_d.rvalid = 1'b1;
                        do_fill = HAS_DCACHE && s_q.fill;
                    end
                    s_d.state = ST_DONE;
                end
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase
        if (!rst_n)
        begin
            s_d = '0;
            s_d.state = ST_IDLE;
        end
    end

    // state register
    always_ff @(posedge core_clk)
    begin
        s_q <= s_d;
    end

    // cache arrays; no reset on data, valid bits cleared by reset or init
    always_ff @(posedge core_clk)
    begin
        if (!rst_n || do_inv_all)
            line_ok <= '0;
        else if (do_inv)
            line_ok[idx] <= 1'b0;
        else if (do_fill)
            line_ok[s_q.idx] <= 1'b1;
        if (do_fill)
        begin
            line_data[s_q.idx] <= bus_rdata;
            line_tag[s_q.idx] <= s_q.frame;
            line_wsel[s_q.idx] <= s_q.addr[3:2];
        end
        else if (do_wr_cache)
        begin
            for (int b = 0; b < 4; b++)
                if (st_be[b])
                    line_data[idx][8*b +: 8] <= st_lanes[8*b +: 8];
        end
    end

    // one request in flight keeps bus cycles in program order
    assign req_ready = (s_q.state == ST_IDLE);
    assign rsp_valid = s_q.rvalid;
    assign rsp_rdata = s_q.rdata;
    // single shared bus for memory and peripherals
    assign bus_read = (s_q.state == ST_BUS) && s_q.is_load;
    assign bus_write = (s_q.state == ST_BUS) && !s_q.is_load;
    assign bus_addr = s_q.addr;
    assign bus_byteenable = s_q.be;
    assign bus_wdata = s_q.wdata;

    // io loads always reach the bus
    property p_io_load_bus;
        @(posedge core_clk) disable iff (!rst_n)
        (req_valid && req_ready && req_io && req_op == lsu_pkg::LSU_OP_LOAD) |=> bus_read;
    endproperty
    a_io_load_bus: assert property (p_io_load_bus) else $error("io load skipped bus");

    // every store, io or not, always reaches the bus
    property p_io_store_bus;
        @(posedge core_clk) disable iff (!rst_n)
        (req_valid && req_ready && req_op == lsu_pkg::LSU_OP_STORE) |=> bus_write;
    endproperty
    a_io_store_bus: assert property (p_io_store_bus) else $error("store skipped bus");

    // bus request held stable while waiting
    sequence s_wait;
        (bus_read || bus_write) && bus_waitrequest;
    endsequence
    property p_hold;
        @(posedge core_clk) disable iff (!rst_n)
        s_wait |=> $stable(bus_addr) && $stable(bus_byteenable) && (bus_read || bus_write);
    endproperty
    a_hold: assert property (p_hold) else $error("bus cycle dropped");

    // byte store enables exactly one lane
    property p_byte_be;
        @(posedge core_clk) disable iff (!rst_n)
        (req_valid && req_ready && req_op == lsu_pkg::LSU_OP_STORE
            && req_size == lsu_pkg::LSU_BYTE) |=> $countones(bus_byteenable) == 1;
    endproperty
    a_byte_be: assert property (p_byte_be) else $error("byte enable count");

    // unsigned byte load leaves upper bits zero
    property p_zero_ext;
        @(posedge core_clk) disable iff (!rst_n)
        (bus_read && !bus_waitrequest && s_q.size == lsu_pkg::LSU_BYTE && !s_q.sgn)
            |=> rsp_valid && rsp_rdata[31:8] == 24'h0;
    endproperty
    a_zero_ext: assert property (p_zero_ext) else $error("zero extension");

    // signed half load copies bit 15 upward
    property p_sign_ext;
        @(posedge core_clk) disable iff (!rst_n)
        (bus_read && !bus_waitrequest && s_q.size == lsu_pkg::LSU_HALF && s_q.sgn)
            |=> rsp_rdata[31:16] == {16{rsp_rdata[15]}};
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extension");

    // no MMU keeps bit 31 off the bus
    property p_addr31;
        @(posedge core_clk) disable iff (!rst_n)
        (bus_read || bus_write) |-> (HAS_MMU || !bus_addr[31]);
    endproperty
    a_addr31: assert property (p_addr31) else $error("bit 31 on bus");

    // a load answers the cycle after its bus read ends, then goes idle
    property p_done;
        @(posedge core_clk) disable iff (!rst_n)
        (bus_read && !bus_waitrequest) |=> rsp_valid ##1 req_ready;
    endproperty
    a_done: assert property (p_done) else $error("load did not complete");

    // request accepted in this cycle
    sequence s_take;
        req_valid && req_ready;
    endsequence

    // a cached hit answers next cycle with no bus cycle
    property p_hit_fast;
        @(posedge core_clk) disable iff (!rst_n)
        s_take ##0 (req_op == lsu_pkg::LSU_OP_LOAD && hit) |=> rsp_valid && req_ready && !bus_read;
    endproperty
    a_hit_fast: assert property (p_hit_fast) else $error("hit went to bus");

    // io accesses never consult or update the cache
    property p_io_uncached;
        @(posedge core_clk) disable iff (!rst_n)
        s_take ##0 req_io |-> !hit && !do_wr_cache;
    endproperty
    a_io_uncached: assert property (p_io_uncached) else $error("io touched cache");

    // cache ops and empty ops make no bus cycle
    property p_no_mem_op;
        @(posedge core_clk) disable iff (!rst_n)
        s_take ##0 (req_op == lsu_pkg::LSU_OP_INIT || req_op == lsu_pkg::LSU_OP_FLUSH
            || req_op == lsu_pkg::LSU_OP_NONE) |=> req_ready && !bus_read && !bus_write;
    endproperty
    a_no_mem_op: assert property (p_no_mem_op) else $error("non-access used bus");
endmodule // lsu_core

// ==== logic/lsu_lane.sv ====
// byte-lane steering and load extension for the 32-bit little-endian bus
`timescale 1ns/100ps
`include "lsu_consts.svh"
module lsu_lane (
    // access description
    input wire logic [1:0] addr_lo,
    input wire lsu_pkg::lsu_size_e size,
    input wire logic is_signed,
    // store side
    input wire logic [31:0] st_src,
    output logic [31:0] st_lanes,
    output logic [3:0] st_be,
    // load side
    input wire logic [31:0] ld_bus,
    output logic [31:0] ld_result
);
    logic [31:0] shifted; // read word moved down to bit 0

    // lanes and enables follow the low address bits
    always_comb
    begin
        st_lanes = st_src;
        st_be = 4'hf;
        shifted = ld_bus >> {addr_lo, 3'h0};
        ld_result = shifted;
        case (size)
            lsu_pkg::LSU_BYTE:
            begin
                st_lanes = {4{st_src[7:0]}};
                st_be = 4'h1 << addr_lo;
                ld_result = {{24{is_signed & shifted[7]}}, shifted[7:0]};
            end
            lsu_pkg::LSU_HALF:
            begin
                st_lanes = {2{st_src[15:0]}};
                st_be = 4'h3 << {addr_lo[1], 1'b0};
                ld_result = {{16{is_signed & shifted[15]}}, shifted[15:0]};
            end
            default:
            begin
                st_lanes = st_src;
                st_be = 4'hf;
                ld_result = ld_bus;
            end
        endcase
    end
endmodule // lsu_lane

// ==== logic/lsu_pkg.sv ====
// types shared by the load/store unit files
package lsu_pkg;
    // access width
    typedef enum logic [1:0] {LSU_BYTE, LSU_HALF, LSU_WORD} lsu_size_e;
    // operation class
    typedef enum logic [2:0] {LSU_OP_NONE, LSU_OP_LOAD, LSU_OP_STORE, LSU_OP_INIT,
        LSU_OP_FLUSH} lsu_op_e;
endpackage

// ==== tb/load_store_unit_tb.sv ====
// self-checking bench for the load/store unit against a memory model
`timescale 1ns/100ps
module load_store_unit_tb;
    logic core_clk = 1'b0; // 10 MHz core clock
    logic rst_n = 1'b0; // held low 16 cycles
    // request side
    logic req_valid = 1'b0;
    logic req_ready;
    lsu_pkg::lsu_op_e req_op = lsu_pkg::LSU_OP_NONE;
    lsu_pkg::lsu_size_e req_size = lsu_pkg::LSU_WORD;
    logic req_signed = 1'b0;
    logic req_io = 1'b0;
    logic [31:0] req_base = 32'h0;
    logic [15:0] req_imm = 16'h0;
    logic [31:0] req_wdata = 32'h0;
    logic rsp_valid;
    logic [31:0] rsp_rdata;
    // bus between unit and model
    logic bus_read;
    logic bus_write;
    logic [31:0] bus_addr;
    logic [3:0] bus_byteenable;
    logic [31:0] bus_wdata;
    logic [31:0] bus_rdata;
    logic bus_waitrequest;
    logic [3:0] wait_n = 4'h0;
    // second unit: mmu build without cache, with its own memory
    logic alt_sel = 1'b0; // route requests to the second unit
    logic alt_ready;
    logic alt_rsp_valid;
    logic [31:0] alt_rsp_rdata;
    logic alt_read;
    logic alt_write;
    logic [31:0] alt_addr;
    logic [3:0] alt_be;
    logic [31:0] alt_wdata;
    logic [31:0] alt_rdata;
    logic alt_wait;
    // view of whichever unit the requests go to
    wire m_ready = alt_sel ? alt_ready : req_ready;
    wire m_rsp_valid = alt_sel ? alt_rsp_valid : rsp_valid;
    wire [31:0] m_rsp_rdata = alt_sel ? alt_rsp_rdata : rsp_rdata;
    wire m_strobe = alt_sel ? (alt_read | alt_write) : (bus_read | bus_write);
    wire [31:0] m_addr = alt_sel ? alt_addr : bus_addr;
    wire [3:0] m_be = alt_sel ? alt_be : bus_byteenable;
    // bench bookkeeping
    int n_errors = 0;
    int checks_done = 0;
    int n_bus; // cycles with a bus strobe in the last request
    int r0; // read count snapshot
    logic [31:0] rd; // last load result
    logic [31:0] seen_addr; // last bus address seen
    logic [3:0] seen_be; // last byte enables seen
    logic [31:0] w; // reference word
    logic [7:0] b8;
    logic [15:0] h16;

    // free-running clock
    always #50 core_clk = ~core_clk;

    // translation inputs unused without an mmu
    lsu_core dut_u (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid & ~alt_sel),
        .req_ready(req_ready), .req_op(req_op), .req_size(req_size), .req_signed(req_signed),
        .req_io(req_io), .req_base(req_base), .req_imm(req_imm), .req_wdata(req_wdata),
        .xlat_frame(20'h0), .xlat_cacheable(1'b1), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .bus_read(bus_read), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_byteenable(bus_byteenable), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_waitrequest(bus_waitrequest));
    lsu_mem_model mem_u (.core_clk(core_clk), .bus_read(bus_read), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_byteenable(bus_byteenable), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .bus_waitrequest(bus_waitrequest), .wait_n(wait_n));
    // mmu present, no cache: bit 31 is a plain address bit, cache ops do nothing
    lsu_core #(.HAS_MMU(1'b1), .HAS_BYPASS31(1'b0), .HAS_DCACHE(1'b0)) dut2_u (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid & alt_sel),
        .req_ready(alt_ready), .req_op(req_op), .req_size(req_size), .req_signed(req_signed),
        .req_io(req_io), .req_base(req_base), .req_imm(req_imm), .req_wdata(req_wdata),
        .xlat_frame(20'h0), .xlat_cacheable(1'b1), .rsp_valid(alt_rsp_valid),
        .rsp_rdata(alt_rsp_rdata), .bus_read(alt_read), .bus_write(alt_write),
        .bus_addr(alt_addr), .bus_byteenable(alt_be), .bus_wdata(alt_wdata),
        .bus_rdata(alt_rdata), .bus_waitrequest(alt_wait));
    lsu_mem_model mem2_u (.core_clk(core_clk), .bus_read(alt_read), .bus_write(alt_write),
        .bus_addr(alt_addr), .bus_byteenable(alt_be), .bus_wdata(alt_wdata),
        .bus_rdata(alt_rdata), .bus_waitrequest(alt_wait), .wait_n(wait_n));

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one request, entered just after an edge while idle; waits for idle again
    task automatic do_req(input lsu_pkg::lsu_op_e op, input lsu_pkg::lsu_size_e sz,
        input logic sg, input logic io, input logic [31:0] base, input logic [15:0] imm,
        input logic [31:0] wd);
        int k;
        rd = 'x;
        n_bus = 0;
        req_valid = 1'b1;
        req_op = op;
        req_size = sz;
        req_signed = sg;
        req_io = io;
        req_base = base;
        req_imm = imm;
        req_wdata = wd;
        @(posedge core_clk);
        #1;
        req_valid = 1'b0;
        for (k = 0; k < 40; k++)
        begin
            if (m_rsp_valid === 1'b1)
                rd = m_rsp_rdata;
            if (m_strobe === 1'b1)
            begin
                n_bus++;
                seen_addr = m_addr;
                seen_be = m_be;
            end
            if (m_ready === 1'b1)
                break;
            @(posedge core_clk);
            #1;
        end
        if (k == 40)
            chk(32'h0, 32'h1);
        // one edge with valid low before the next request raises it again
        @(posedge core_clk);
        #1;
    endtask

    // word load helper
    task automatic ldw(input logic io, input logic [31:0] a);
        do_req(lsu_pkg::LSU_OP_LOAD, lsu_pkg::LSU_WORD, 1'b0, io, a, 16'h0, 32'h0);
    endtask

    // io loads of every width and sign through a slow memory
    task automatic t_loads;
        wait_n = 4'h2;
        w = 32'h8a7f_43e1;
        for (int o = 0; o < 4; o++)
            for (int s = 0; s < 2; s++)
            begin
                do_req(lsu_pkg::LSU_OP_LOAD, lsu_pkg::LSU_BYTE, s[0], 1'b1, 32'h10,
                    16'hfff0 + 16'(o), 32'h0);
                b8 = w[o*8 +: 8];
                chk(rd, s ? {{24{b8[7]}}, b8} : {24'h0, b8});
                chk(seen_addr, 32'h0);
                if (o[0] == 1'b0)
                begin
                    do_req(lsu_pkg::LSU_OP_LOAD, lsu_pkg::LSU_HALF, s[0], 1'b1, 32'(o),
                        16'h0, 32'h0);
                    h16 = w[o*8 +: 16];
                    chk(rd, s ? {{16{h16[15]}}, h16} : {16'h0, h16});
                end
            end
        ldw(1'b1, 32'h0);
        chk(rd, w);
        chk(32'(n_bus), 32'h3);
        wait_n = 4'h0;
        $display("test loads done");
    endtask

    // io sub-word stores: lanes, enables and untouched bytes
    task automatic t_stores;
        for (int o = 0; o < 4; o++)
        begin
            do_req(lsu_pkg::LSU_OP_STORE, lsu_pkg::LSU_BYTE, 1'b0, 1'b1, 32'h4 + 32'(o),
                16'h0, 32'hdead_be00 | 32'(8'h11 * (o + 1)));
            chk(32'(seen_be), 32'(4'h1 << o));
        end
        chk(mem_u.mem[1], 32'h4433_2211);
        do_req(lsu_pkg::LSU_OP_STORE, lsu_pkg::LSU_HALF, 1'b0, 1'b1, 32'h6, 16'h0,
            32'hffff_a5b6);
        chk(32'(seen_be), 32'hc);
        chk(mem_u.mem[1], 32'ha5b6_2211);
        $display("test stores done");
    endtask

    // cached hits, io and bit-31 bypass, tags, flush and init
    task automatic t_cache;
        r0 = mem_u.n_reads;
        ldw(1'b0, 32'h8);
        ldw(1'b0, 32'h8);
        chk(rd, 32'h1234_5678);
        chk(32'(mem_u.n_reads - r0), 32'h1);
        ldw(1'b1, 32'h8);
        ldw(1'b1, 32'h8);
        chk(32'(mem_u.n_reads - r0), 32'h3);
        ldw(1'b0, 32'h8000_0008);
        chk(seen_addr, 32'h8);
        ldw(1'b0, 32'h8000_0008);
        chk(32'(mem_u.n_reads - r0), 32'h5);
        ldw(1'b0, 32'h1008);
        chk(32'(mem_u.n_reads - r0), 32'h6);
        ldw(1'b0, 32'h8);
        do_req(lsu_pkg::LSU_OP_STORE, lsu_pkg::LSU_WORD, 1'b0, 1'b0, 32'h8, 16'h0,
            32'h0bad_f00d);
        chk(mem_u.mem[2], 32'h0bad_f00d);
        do_req(lsu_pkg::LSU_OP_NONE, lsu_pkg::LSU_WORD, 1'b0, 1'b0, 32'h8, 16'h0, 32'h0);
        chk(32'(n_bus), 32'h0);
        r0 = mem_u.n_reads;
        ldw(1'b0, 32'h8);
        chk(rd, 32'h0bad_f00d);
        do_req(lsu_pkg::LSU_OP_FLUSH, lsu_pkg::LSU_WORD, 1'b0, 1'b0, 32'h8, 16'h0, 32'h0);
        ldw(1'b0, 32'h8);
        do_req(lsu_pkg::LSU_OP_INIT, lsu_pkg::LSU_WORD, 1'b0, 1'b0, 32'h0, 16'h0, 32'h0);
        ldw(1'b0, 32'h8);
        chk(32'(mem_u.n_reads - r0), 32'h2);
        ldw(1'b0, 32'h4);
        chk(rd, 32'ha5b6_2211);
        r0 = mem_u.n_reads;
        do_req(lsu_pkg::LSU_OP_LOAD, lsu_pkg::LSU_BYTE, 1'b1, 1'b0, 32'h7, 16'h0, 32'h0);
        chk(rd, 32'hffff_ffa5);
        chk(32'(mem_u.n_reads - r0), 32'h0);
        $display("test cache done");
    endtask

    // mmu build without cache: bit 31 stays an address bit, loads always reach the bus
    task automatic t_config;
        alt_sel = 1'b1;
        mem2_u.mem[2] = 32'h5a5a_0f0f;
        r0 = mem2_u.n_reads;
        ldw(1'b0, 32'h8000_0008);
        chk(seen_addr, 32'h8000_0008);
        chk(rd, 32'h5a5a_0f0f);
        do_req(lsu_pkg::LSU_OP_INIT, lsu_pkg::LSU_WORD, 1'b0, 1'b0, 32'h0, 16'h0, 32'h0);
        chk(32'(n_bus), 32'h0);
        ldw(1'b0, 32'h8000_0008);
        chk(32'(mem2_u.n_reads - r0), 32'h2);
        alt_sel = 1'b0;
        $display("test config done");
    endtask

    // verdict, the only end of the run
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // main sequence
    initial
    begin
        mem_u.mem[0] = 32'h8a7f_43e1;
        mem_u.mem[1] = 32'h0;
        mem_u.mem[2] = 32'h1234_5678;
        repeat (16) @(posedge core_clk);
        #1;
        rst_n = 1'b1;
        t_loads();
        t_stores();
        t_cache();
        t_config();
        report_and_stop();
    end

    // watchdog: tests need well under 1000 cycles
    initial
    begin
        #(100 * 5000);
        n_errors++;
        report_and_stop();
    end
endmodule // load_store_unit_tb

// ==== tb/lsu_mem_model.sv ====
// memory partner model on the data bus, with programmable wait states
`timescale 1ns/100ps
module lsu_mem_model (
    // clock
    input wire logic core_clk,
    // data bus from the unit
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic [31:0] bus_addr,
    input wire logic [3:0] bus_byteenable,
    input wire logic [31:0] bus_wdata,
    output logic [31:0] bus_rdata,
    output logic bus_waitrequest,
    // wait states per access, set by the bench while idle
    input wire logic [3:0] wait_n
);
    logic [31:0] mem [16]; // word store, wraps every 64 bytes
    logic [31:0] last_q = 32'h0; // last value returned
    logic [3:0] cnt_q = 4'h0; // wait states served so far
    int n_reads = 0; // completed reads, used for cache checks
    int n_writes = 0; // completed writes
    wire act = bus_read | bus_write;
    // stall until the wait count is served
    assign bus_waitrequest = act && (cnt_q != wait_n);
    // outside the data phase show the inverse, so a stale sample cannot pass
    assign bus_rdata = (bus_read && !bus_waitrequest) ? mem[bus_addr[5:2]] : ~last_q;
    // serve one access: count waits, then read or write by lane
    always @(posedge core_clk)
    begin
        if (act && bus_waitrequest)
        begin
            cnt_q <= cnt_q + 4'h1;
        end
        else if (act)
        begin
            cnt_q <= 4'h0;
            if (bus_read)
            begin
                last_q <= mem[bus_addr[5:2]];
                n_reads <= n_reads + 1;
            end
            else
            begin
                n_writes <= n_writes + 1;
            end
            for (int b = 0; b < 4; b++)
            begin
                if (bus_write && bus_byteenable[b])
                begin
                    mem[bus_addr[5:2]][b*8 +: 8] <= bus_wdata[b*8 +: 8];
                end
            end
        end
    end
endmodule // lsu_mem_model
